// *** rtl/udf_pkg.sv ***
// package: offsets, reset values, field layout and structs for the unknown-destination forward control
package udf_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_RSVD_LOW   = 8'h82;
    localparam logic [7:0] OFS_UCAST_CTRL = 8'h83;
    localparam logic [7:0] OFS_MCAST_CTRL = 8'h84;
    localparam logic [7:0] OFS_VLAN_CTRL  = 8'h85;
    localparam logic [7:0] OFS_SELF_CTRL  = 8'h86;
    localparam logic [7:0] OFS_MAC_FIRST  = 8'h68;
    localparam int         MAC_BYTES      = 6;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int EN_BIT      = 5;
    localparam int SELF_BIT    = 6;
    localparam int MAP_MSB     = 4;
    localparam int DRIVE_LSB   = 6;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_RSVD_LOW = 8'h04;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [1:0] RST_DRIVE    = 2'h1;

    // ----------------------------------------
    // frame classes and decision
    // ----------------------------------------
    typedef enum logic [2:0] {
        UDF_CLS_KNOWN = 3'b000,
        UDF_CLS_UCAST = 3'b001,
        UDF_CLS_MCAST = 3'b010,
        UDF_CLS_VLAN  = 3'b011,
        UDF_CLS_IPMC  = 3'b100
    } udf_class_e;

    typedef struct packed {
        logic       valid;
        udf_class_e cls;
        logic [3:0] known_ports;
        logic       dst_is_self;
        logic [3:0] egress_port;
    } udf_req_s;

    typedef struct packed {
        logic       valid;
        logic       drop;
        logic [3:0] ports;
        logic       self_drop;
    } udf_rsp_s;

endpackage : udf_pkg

// *** rtl/udf_map_decode.sv ***
// port-map decoder shared by the four unknown-destination frame classes
`timescale 1ns/1ps
`default_nettype none
module udf_map_decode (
    input  wire logic       en,
    input  wire logic [4:0] map,
    output var  logic [3:0] ports,
    output var  logic       drop
);
    always_comb begin
        // bit 0 reserved; bits 4..1 pick ports 4..1
        ports = en ? map[udf_pkg::MAP_MSB:1] : 4'h0;
        drop  = en && (map[udf_pkg::MAP_MSB:1] == 4'h0);
    end
endmodule : udf_map_decode
`default_nettype wire

// *** rtl/udf_fwd_ctrl.sv ***
// register bank and forwarding decision for unknown-destination frames
// How it works
// - the unknown-unicast enable bit 5 turns on map forwarding of unknown unicast, off when clear.
// - the unicast map drops on zero, bits 4..1 pick ports, bit 0 is ignored.
// - a separate enable turns on map forwarding of unknown non-IP multicast.
// - the multicast map uses the same five-bit encoding.
// - a separate enable turns on map forwarding of unknown-VLAN frames.
// - the VLAN map uses the same encoding with bit 0 reserved.
// - a separate enable turns on map forwarding of unknown IP multicast.
// - the IP multicast map uses the same encoding.
// - the self-address filter bit 6 drops frames addressed to the switch itself.
// - self filtering acts at egress on the dst_is_self input; the MAC held at addresses 104 to 109 is only stored and read back.
`timescale 1ns/1ps
`default_nettype none
module udf_fwd_ctrl (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output var  logic [7:0]       reg_rdata,
    output var  logic             reg_rvalid,
    input  wire udf_pkg::udf_req_s req,
    output var  udf_pkg::udf_rsp_s rsp,
    output var  logic [1:0]       drive_sel
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0]  ucast_q;
    logic [7:0]  mcast_q;
    logic [5:0]  vlan_q;
    logic [6:0]  self_q;
    logic [47:0] mac_q;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // address selects byte idx of the switch address
    function automatic logic mac_byte_hit(input logic [7:0] addr, input int idx);
        mac_byte_hit = (addr == 8'(udf_pkg::OFS_MAC_FIRST + 8'(idx)));
    endfunction : mac_byte_hit

    // lowest bit of byte idx, first byte most significant
    function automatic int mac_byte_lsb(input int idx);
        mac_byte_lsb = 8 * (udf_pkg::MAC_BYTES - 1 - idx);
    endfunction : mac_byte_lsb

    // ports left once the egress port of a self-addressed frame is removed
    function automatic logic [3:0] strip_egress(input logic [3:0] dst, input logic [3:0] egress, input logic hit);
        strip_egress = hit ? (dst & ~egress) : dst;
    endfunction : strip_egress

    // unicast control, bits 7:6 not stored
    always_ff @(posedge clk) begin
        if (srst) begin
            ucast_q <= udf_pkg::RST_CTRL[5:0];
        end else if (reg_wr && reg_addr == udf_pkg::OFS_UCAST_CTRL) begin
            ucast_q <= reg_wdata[5:0];
        end
    end

    // drive strength and multicast control, all bits stored
    always_ff @(posedge clk) begin
        if (srst) begin
            mcast_q <= {udf_pkg::RST_DRIVE, udf_pkg::RST_CTRL[5:0]};
        end else if (reg_wr && reg_addr == udf_pkg::OFS_MCAST_CTRL) begin
            mcast_q <= reg_wdata;
        end
    end

    // vlan control, bits 7:6 not stored
    always_ff @(posedge clk) begin
        if (srst) begin
            vlan_q <= udf_pkg::RST_CTRL[5:0];
        end else if (reg_wr && reg_addr == udf_pkg::OFS_VLAN_CTRL) begin
            vlan_q <= reg_wdata[5:0];
        end
    end

    // self filter and ip multicast control, bit 7 not stored
    always_ff @(posedge clk) begin
        if (srst) begin
            self_q <= udf_pkg::RST_CTRL[6:0];
        end else if (reg_wr && reg_addr == udf_pkg::OFS_SELF_CTRL) begin
            self_q <= reg_wdata[6:0];
        end
    end

    // ----------------------------------------
    // switch address
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            mac_q <= 48'h0000_0000_0000;
        end else if (reg_wr) begin
            for (int i = 0; i < udf_pkg::MAC_BYTES; i++) begin
                if (mac_byte_hit(reg_addr, i))
                    mac_q[mac_byte_lsb(i) +: 8] <= reg_wdata;
            end
        end
    end

    // drive strength field, one cycle behind its register
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_sel <= udf_pkg::RST_DRIVE;
        end else begin
            drive_sel <= mcast_q[udf_pkg::DRIVE_LSB +: 2];
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    logic [7:0] rd_d;
    always_comb begin
        rd_d = 8'h00;
        case (reg_addr)
            udf_pkg::OFS_RSVD_LOW:   rd_d = udf_pkg::RST_RSVD_LOW;
            udf_pkg::OFS_UCAST_CTRL: rd_d = {2'b00, ucast_q};
            udf_pkg::OFS_MCAST_CTRL: rd_d = mcast_q;
            udf_pkg::OFS_VLAN_CTRL:  rd_d = {2'b00, vlan_q};
            udf_pkg::OFS_SELF_CTRL:  rd_d = {1'b0, self_q};
            default: begin
                for (int i = 0; i < udf_pkg::MAC_BYTES; i++) begin
                    if (mac_byte_hit(reg_addr, i))
                        rd_d = mac_q[mac_byte_lsb(i) +: 8];
                end
            end
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end
    end

    // answer strobe one cycle after each read
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // ----------------------------------------
    // map select and decode
    // ----------------------------------------
    logic       sel_en;
    logic [4:0] sel_map;
    logic [3:0] map_ports;
    logic       map_drop;
    always_comb begin
        sel_en  = 1'b0;
        sel_map = 5'h00;
        case (req.cls)
            udf_pkg::UDF_CLS_UCAST: begin
                sel_en  = ucast_q[udf_pkg::EN_BIT];
                sel_map = ucast_q[4:0];
            end
            udf_pkg::UDF_CLS_MCAST: begin
                sel_en  = mcast_q[udf_pkg::EN_BIT];
                sel_map = mcast_q[4:0];
            end
            udf_pkg::UDF_CLS_VLAN: begin
                sel_en  = vlan_q[udf_pkg::EN_BIT];
                sel_map = vlan_q[4:0];
            end
            udf_pkg::UDF_CLS_IPMC: begin
                sel_en  = self_q[udf_pkg::EN_BIT];
                sel_map = self_q[4:0];
            end
            default: ;
        endcase
    end

    udf_map_decode u_dec (
        .en    (sel_en),
        .map   (sel_map),
        .ports (map_ports),
        .drop  (map_drop)
    );

    // ----------------------------------------
    // decision
    // ----------------------------------------
    logic self_hit;
    always_comb begin
        // egress filter: frame for own address, on the port it would leave by
        self_hit = self_q[udf_pkg::SELF_BIT] && req.dst_is_self && (req.egress_port != 4'h0);
    end

    // next response, registered below so the output leaves a flop
    udf_pkg::udf_rsp_s rsp_d;
    always_comb begin
        rsp_d           = '0;
        rsp_d.valid     = req.valid;
        rsp_d.self_drop = req.valid && self_hit;
        if (req.cls == udf_pkg::UDF_CLS_KNOWN || !sel_en) begin
            // disabled class keeps its normal destination
            rsp_d.drop  = req.valid && self_hit;
            rsp_d.ports = strip_egress(req.known_ports, req.egress_port, self_hit);
        end else begin
            rsp_d.drop  = req.valid && (map_drop || self_hit);
            rsp_d.ports = strip_egress(map_ports, req.egress_port, self_hit);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp <= '0;
        end else begin
            rsp <= rsp_d;
        end
    end

endmodule : udf_fwd_ctrl
`default_nettype wire

// *** dv/udf_fwd_chk.sv ***
// checker: port assertions for the forward control
`timescale 1ns/1ps
`default_nettype none
module udf_fwd_chk (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    input wire udf_pkg::udf_req_s req,
    input wire udf_pkg::udf_rsp_s rsp,
    input wire logic [1:0]        drive_sel
);
    logic self_q;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // shadow of the self filter enable
    always_ff @(posedge clk) begin
        if (srst)
            self_q <= 1'b0;
        else if (reg_wr && reg_addr == udf_pkg::OFS_SELF_CTRL)
            self_q <= reg_wdata[6];
    end
    sequence s_self_hit;
        req.valid && req.dst_is_self && (|req.egress_port) && self_q;
    endsequence
    sequence s_drv_wr;
        reg_wr && reg_addr == udf_pkg::OFS_MCAST_CTRL;
    endsequence
    property p_drive;
        logic [1:0] v;
        (s_drv_wr, v = reg_wdata[7:6]) |=> ##1 drive_sel == v;
    endproperty
    property p_self_port;
        logic [3:0] e;
        (s_self_hit, e = req.egress_port) |=> (rsp.ports & e) == 4'h0;
    endproperty
    a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
    a_rd_quiet: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
    a_rsvd_read: assert property (reg_rd && reg_addr == udf_pkg::OFS_RSVD_LOW |=> reg_rdata == 8'h04)
        else $error("reserved byte wrong");
    a_drive_lag: assert property (p_drive) else $error("drive select wrong");
    a_self_drop: assert property (s_self_hit |=> rsp.drop && rsp.self_drop) else $error("no self drop");
    a_self_port: assert property (p_self_port) else $error("egress port kept");
    a_self_off: assert property (req.valid && !self_q |=> !rsp.self_drop) else $error("stray self drop");
    a_known_pass: assert property (req.valid && req.cls == udf_pkg::UDF_CLS_KNOWN && !self_q
        |=> !rsp.drop && rsp.ports == $past(req.known_ports)) else $error("known frame altered");
endmodule : udf_fwd_chk
bind udf_fwd_ctrl udf_fwd_chk udf_fwd_chk_i (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .req, .rsp, .drive_sel);
`default_nettype wire

// *** dv/testbench.sv ***
// testbench: register and forwarding checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic              clk, srst, reg_wr, reg_rd, reg_rvalid;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata;
    logic [1:0]        drive_sel;
    udf_pkg::udf_req_s req;
    udf_pkg::udf_rsp_s rsp;
    int                mismatches, n_compared;
    udf_fwd_ctrl udf_fwd_ctrl_i (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .req, .rsp, .drive_sel);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({7'h0, reg_rvalid}, 8'h01);
        chk(reg_rdata, e);
    endtask : rd
    task automatic fr(input udf_pkg::udf_class_e c, input logic [3:0] kp, input logic s, input logic [3:0] eg,
                      input logic [5:0] e);
        @(negedge clk);
        req = '{1'b1, c, kp, s, eg};
        @(negedge clk);
        req.valid = 1'b0;
        chk({1'b0, rsp}, {2'h1, e});
    endtask : fr
    task automatic t_regs;
        logic [7:0] ra [6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h90};
        logic [7:0] rv [6] = '{8'h04, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
        logic [7:0] mv [6] = '{8'h04, 8'h3f, 8'hff, 8'h3f, 8'h7f, 8'h00};
        chk({6'h0, drive_sel}, 8'h01);
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
        for (int i = 0; i < 6; i++) wr(ra[i], 8'hff);
        for (int i = 0; i < 6; i++) rd(ra[i], mv[i]);
        chk({6'h0, drive_sel}, 8'h03);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_maps;
        udf_pkg::udf_class_e cl [4] = '{udf_pkg::UDF_CLS_UCAST, udf_pkg::UDF_CLS_MCAST,
                                        udf_pkg::UDF_CLS_VLAN, udf_pkg::UDF_CLS_IPMC};
        logic [4:0] mp [6] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h07, 5'h1e};
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 6; j++) begin
                wr(8'(8'h83 + i), {3'h1, mp[j]});
                fr(cl[i], 4'h9, 1'b0, 4'h0, {mp[j][4:1] == 4'h0, mp[j][4:1], 1'b0});
            end
            wr(8'(8'h83 + i), 8'h1e);
            fr(cl[i], 4'h9, 1'b0, 4'h0, 6'h12);
        end
        $display("t_maps done");
    endtask : t_maps
    task automatic t_self;
        wr(8'h86, 8'h40);
        fr(udf_pkg::UDF_CLS_KNOWN, 4'hf, 1'b1, 4'h2, 6'h3b);
        fr(udf_pkg::UDF_CLS_KNOWN, 4'hf, 1'b0, 4'h2, 6'h1e);
        wr(8'h86, 8'h00);
        fr(udf_pkg::UDF_CLS_KNOWN, 4'hf, 1'b1, 4'h2, 6'h1e);
        for (int i = 0; i < 6; i++) wr(8'(8'h68 + i), 8'(8'ha0 + i));
        for (int i = 0; i < 6; i++) rd(8'(8'h68 + i), 8'(8'ha0 + i));
        $display("t_self done");
    endtask : t_self
    task automatic t_reset;
        wr(8'h84, 8'hbf);
        @(negedge clk);
        chk({6'h0, drive_sel}, 8'h02);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk({1'b0, rsp}, 8'h00);
        chk({7'h0, reg_rvalid}, 8'h00);
        chk({6'h0, drive_sel}, 8'h01);
        rd(8'h84, 8'h40);
        rd(8'h83, 8'h00);
        rd(8'h68, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {srst, reg_wr, reg_rd, reg_addr, reg_wdata, req} = {3'h4, 16'h0, 13'h0};
        repeat (6) @(negedge clk);
        srst = 1'b0;
        t_regs;
        t_maps;
        t_self;
        t_reset;
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        report_and_stop;
    end
endmodule : testbench
`default_nettype wire
